// file: iaec_arbiter.sv
// Interrupt arbiter with central control, external and peripheral channels
//
// Functional notes
// - Peripheral pending set by trigger, software may set, clear and read it
// - Peripheral request only with mask, pending and global enable all set
// - Three-bit level, zero highest, level seven never acknowledged
// - Each channel supplies a seven-bit vector selecting a table entry
// - Arbitration resolves in six core cycles, independent of instructions
// - Pending requests sampled once every five core cycles
// - Abort current instruction if no write yet, else finish it first
// - External channel event to service start within 26 to 48 cycles
// - Non-maskable top-level event to service start within 22 to 48 cycles
// - Machine cycle 18, plus 2 for register-file stack, plus 2 segment push
// - Waiting core adds one wake-up cycle to the response
// - Central control bit 7 drives the multifunction timer enable
// - Top-level pending set by event or software, cleared on acknowledge
// - Top-level request needs mask with enable, or the not-maskable setting
// - Global enable cleared by machine cycle, set by return, ei, di controls; top-level machine cycle and return leave it unchanged
// - Mode bit selects concurrent or nested; nested rewrites current level
// - Edge select 0 falling, 1 rising; channel D1 edge bit stays cleared
// - External pending set on edge or by software, cleared on acknowledge
// - External mask 0 blocks; 1 requests when pending and enable set
// - Pairs share two upper level bits; low bit 0 even, 1 odd
// - Nested acknowledge sets hold bit of current level, loads new level
// - Channel D1 input reacts to falling edges only
//
// The Avalon-MM slave port is this design's own decision.
`default_nettype none
module iaec_arbiter
    import iaec_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Avalon-MM slave
    input  wire logic [9:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Interrupt sources
    input  wire logic [NUM_EXT-1:0]   ext_pin,
    input  wire logic                 top_level_pin,
    input  wire logic [NUM_PER-1:0]   per_trigger,
    // CPU sequencer
    input  wire iaec_cpu_t            cpu,
    output logic                      irq_request,
    output iaec_isr_t                 isr,
    // Timer enable
    output logic                      multifunction_timer_enable
);

    iaec_state_t st_r;
    iaec_state_t st_nxt;

    // Level of an external channel from its pair bits and hardware low bit
    function automatic logic [2:0] ext_level(input logic [7:0] prio, input int ch);
        ext_level = {prio[2*(ch/2)+1], prio[2*(ch/2)], ch[0]};
    endfunction

    // Register read view
    function automatic logic [31:0] reg_view(input iaec_state_t s, input logic [7:0] idx);
        reg_view = 32'h0000_0000;
        case (idx)
            IDX_CENTRAL_CTRL: reg_view = {24'h000000, s.cc};
            IDX_EXT_EDGE:     reg_view = {24'h000000, s.edge_sel};
            IDX_EXT_PEND:     reg_view = {24'h000000, s.ext_pend};
            IDX_EXT_MASK:     reg_view = {24'h000000, s.ext_mask};
            IDX_EXT_PRIO:     reg_view = {24'h000000, s.ext_prio};
            IDX_HOLD_LEVEL:   reg_view = {24'h000000, s.hold};
            IDX_CORE_CFG:     reg_view = {24'h000000, s.cfg};
            default: begin
                for (int p = 0; p < NUM_PER; p++) begin
                    if (idx == IDX_PER_BASE + 8'(p)) begin
                        reg_view = {17'h00000, s.per[p]};
                    end
                end
            end
        endcase
    endfunction

    // Apply byte enable 0 to an 8-bit field
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        lane0 = be[0] ? wd[7:0] : old;
    endfunction

    logic [7:0]  edge_hit;
    logic        tl_hit;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  widx;
    logic        tl_req;
    logic [3:0]  best_src;
    logic [2:0]  best_lvl;
    logic [2:0]  lvl;
    logic [4:0]  mc_len;
    logic [2:0]  pop_lvl;
    logic        pop_any;

    always_comb begin
        st_nxt   = st_r;
        edge_hit = 8'h00;
        tl_hit   = 1'b0;
        best_src = SRC_NONE;
        best_lvl = LVL_LOWEST;
        lvl      = LVL_LOWEST;
        tl_req   = 1'b0;
        mc_len   = MC_BASE_CYC;
        pop_lvl  = LVL_LOWEST;
        pop_any  = 1'b0;
        widx     = avs_address[9:2];
        rd_go    = avs_read & ~st_r.bus_done;
        wr_go    = avs_write & st_r.bus_done;

        // Input synchronisers and edge detection
        st_nxt.ext_s1 = ext_pin;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        st_nxt.tl_s1  = top_level_pin;
        st_nxt.tl_s2  = st_r.tl_s1;
        st_nxt.tl_s3  = st_r.tl_s2;
        for (int i = 0; i < NUM_EXT; i++) begin
            if (i == NUM_EXT - 1) begin
                edge_hit[i] = ~st_r.ext_s2[i] & st_r.ext_s3[i];
            end else if (st_r.edge_sel[i]) begin
                edge_hit[i] = st_r.ext_s2[i] & ~st_r.ext_s3[i];
            end else begin
                edge_hit[i] = ~st_r.ext_s2[i] & st_r.ext_s3[i];
            end
        end
        tl_hit = st_r.tl_s2 & ~st_r.tl_s3;

        // Bus handshake: one wait cycle, then the access completes
        st_nxt.bus_done = (avs_read | avs_write) & ~st_r.bus_done;
        if (rd_go) begin
            st_nxt.rdata = reg_view(st_r, widx);
        end

        // Software writes; hardware sets below take precedence
        if (wr_go) begin
            case (widx)
                IDX_CENTRAL_CTRL: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.cc[CC_MFT_EN] = avs_writedata[CC_MFT_EN];
                        st_nxt.cc[CC_TL_PEND] = st_r.cc[CC_TL_PEND]
                                              | avs_writedata[CC_TL_PEND];
                        st_nxt.cc[CC_TL_MASK] = avs_writedata[CC_TL_MASK];
                        // Enable may not drop while an arbitration runs
                        if (st_r.fsm != S_ARB || avs_writedata[CC_IEN]) begin
                            st_nxt.cc[CC_IEN] = avs_writedata[CC_IEN];
                        end
                        st_nxt.cc[CC_MODE] = avs_writedata[CC_MODE];
                        st_nxt.cc[2:0] = avs_writedata[2:0];
                    end
                end
                IDX_EXT_EDGE: begin
                    st_nxt.edge_sel = lane0(st_r.edge_sel, avs_writedata, avs_byteenable);
                    st_nxt.edge_sel[NUM_EXT-1] = 1'b0;
                end
                IDX_EXT_PEND: begin
                    st_nxt.ext_pend = lane0(st_r.ext_pend, avs_writedata,
                                            avs_byteenable);
                end
                IDX_EXT_MASK: begin
                    st_nxt.ext_mask = lane0(st_r.ext_mask, avs_writedata, avs_byteenable);
                end
                IDX_EXT_PRIO: begin
                    st_nxt.ext_prio = lane0(st_r.ext_prio, avs_writedata, avs_byteenable);
                end
                IDX_HOLD_LEVEL: begin
                    // Not-maskable bit is set-only until reset
                    if (avs_byteenable[0]) begin
                        st_nxt.hold = st_r.hold | {avs_writedata[HL_TOP_LEVEL_NOT_MASKABLE], 7'h00};
                        st_nxt.hold[6:0] = avs_writedata[6:0];
                    end
                end
                IDX_CORE_CFG: begin
                    st_nxt.cfg = lane0(st_r.cfg, avs_writedata, avs_byteenable);
                end
                default: begin
                    for (int p = 0; p < NUM_PER; p++) begin
                        if (widx == IDX_PER_BASE + 8'(p)) begin
                            if (avs_byteenable[0]) begin
                                st_nxt.per[p][7:0] = avs_writedata[7:0];
                            end
                            if (avs_byteenable[1]) begin
                                st_nxt.per[p][14:8] = avs_writedata[14:8];
                            end
                        end
                    end
                end
            endcase
        end

        // CPU instruction effects on the global enable
        if (cpu.ei) begin
            st_nxt.cc[CC_IEN] = 1'b1;
        end
        if (cpu.di) begin
            st_nxt.cc[CC_IEN] = 1'b0;
        end
        if (cpu.iret) begin
            if (st_r.in_tl) begin
                st_nxt.in_tl = 1'b0;
            end else begin
                st_nxt.cc[CC_IEN] = 1'b1;
                if (st_r.cc[CC_MODE]) begin
                    for (int h = 6; h >= 0; h--) begin
                        if (st_r.hold[h]) begin
                            pop_lvl = 3'(h);
                            pop_any = 1'b1;
                        end
                    end
                    st_nxt.cc[2:0] = pop_any ? pop_lvl : LVL_LOWEST;
                    if (pop_any) begin
                        st_nxt.hold[pop_lvl] = 1'b0;
                    end
                end
            end
        end

        // Sampling divider
        st_nxt.div = (st_r.div == SAMPLE_CYC - 3'h1) ? 3'h0 : st_r.div + 3'h1;

        // Candidate search over enabled requests
        tl_req = st_r.cc[CC_TL_PEND]
               & (st_r.hold[HL_TOP_LEVEL_NOT_MASKABLE] | (st_r.cc[CC_TL_MASK] & st_r.cc[CC_IEN]));
        for (int i = NUM_EXT - 1; i >= 0; i--) begin
            lvl = ext_level(st_r.ext_prio, i);
            if (st_r.ext_mask[i] & st_r.ext_pend[i] & st_r.cc[CC_IEN]
                && lvl <= best_lvl) begin
                best_lvl = lvl;
                best_src = 4'(i);
            end
        end
        for (int p = NUM_PER - 1; p >= 0; p--) begin
            lvl = st_r.per[p][2:0];
            if (st_r.per[p][PC_MASK] & st_r.per[p][PC_PEND] & st_r.cc[CC_IEN]
                && lvl < best_lvl) begin
                best_lvl = lvl;
                best_src = SRC_PER0 + 4'(p);
            end
        end
        if (best_lvl >= st_r.cc[2:0]) begin
            best_src = SRC_NONE;
        end

        // Interrupt sequencing
        st_nxt.isr.start = 1'b0;
        case (st_r.fsm)
            S_IDLE: begin
                if (st_r.div == SAMPLE_CYC - 3'h1 && !st_r.in_tl
                    && (tl_req || best_src != SRC_NONE)) begin
                    st_nxt.fsm     = S_ARB;
                    st_nxt.cnt     = ARB_CYC - 5'h01;
                    st_nxt.win_tl  = tl_req;
                    st_nxt.win_src = best_src;
                    st_nxt.win_lvl = best_lvl;
                end
            end
            S_ARB: begin
                st_nxt.cnt = st_r.cnt - 5'h01;
                if (st_r.cnt == 5'h00) begin
                    st_nxt.fsm = S_WAIT_ABORT;
                end
            end
            S_WAIT_ABORT: begin
                if (cpu.abortable || cpu.instr_end) begin
                    mc_len = MC_BASE_CYC
                           + (st_r.cfg[CFG_STACK_RF] ? MC_STACK_CYC : 5'h00)
                           + (st_r.cfg[CFG_SEG_PUSH] ? MC_SEG_CYC : 5'h00)
                           + (cpu.wfi ? MC_WAKE_CYC : 5'h00);
                    st_nxt.fsm = S_MACHINE;
                    st_nxt.cnt = mc_len - 5'h01;
                    if (st_r.win_tl) begin
                        st_nxt.cc[CC_TL_PEND] = 1'b0;
                        st_nxt.in_tl = 1'b1;
                    end else begin
                        st_nxt.cc[CC_IEN] = 1'b0;
                        if (st_r.win_src < SRC_PER0) begin
                            st_nxt.ext_pend[st_r.win_src[2:0]] = 1'b0;
                        end else begin
                            st_nxt.per[st_r.win_src[1:0]][PC_PEND] = 1'b0;
                        end
                        if (st_r.cc[CC_MODE]) begin
                            if (st_r.cc[2:0] != LVL_LOWEST) begin
                                st_nxt.hold[st_r.cc[2:0]] = 1'b1;
                            end
                            st_nxt.cc[2:0] = st_r.win_lvl;
                        end
                    end
                end
            end
            S_MACHINE: begin
                st_nxt.cnt = st_r.cnt - 5'h01;
                if (st_r.cnt == 5'h00) begin
                    st_nxt.fsm           = S_IDLE;
                    st_nxt.isr.start     = 1'b1;
                    st_nxt.isr.top_level = st_r.win_tl;
                    if (st_r.win_tl) begin
                        st_nxt.isr.vector = 7'h00;
                    end else if (st_r.win_src < SRC_PER0) begin
                        st_nxt.isr.vector = {st_r.cfg[7:4], st_r.win_src[2:0]};
                    end else begin
                        st_nxt.isr.vector = st_r.per[st_r.win_src[1:0]][14:8];
                    end
                end
            end
            default: begin
                st_nxt.fsm = S_IDLE;
            end
        endcase

        // Hardware trigger sets win over any clear in the same cycle
        st_nxt.ext_pend = st_nxt.ext_pend | edge_hit;
        for (int p = 0; p < NUM_PER; p++) begin
            st_nxt.per[p][PC_PEND] = st_nxt.per[p][PC_PEND] | per_trigger[p];
        end
        if (tl_hit) begin
            st_nxt.cc[CC_TL_PEND] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.cc       <= CC_RESET;
            st_r.ext_prio <= PRIO_RESET;
            st_r.win_src  <= SRC_NONE;
            st_r.fsm      <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata               = st_r.rdata;
    assign avs_waitrequest            = (avs_read | avs_write) & ~st_r.bus_done;
    assign irq_request                = (st_r.fsm == S_WAIT_ABORT);
    assign isr                        = st_r.isr;
    assign multifunction_timer_enable = st_r.cc[CC_MFT_EN];

endmodule
`default_nettype wire

// file: iaec_pkg.sv
// Package: register map, field layout, timing constants and carrier types of the arbiter
`default_nettype none
package iaec_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CENTRAL_CTRL = 8'hE6;
    localparam logic [7:0] IDX_EXT_EDGE     = 8'hF2;
    localparam logic [7:0] IDX_EXT_PEND     = 8'hF3;
    localparam logic [7:0] IDX_EXT_MASK     = 8'hF4;
    localparam logic [7:0] IDX_EXT_PRIO     = 8'hF5;
    localparam logic [7:0] IDX_HOLD_LEVEL   = 8'hF7;
    localparam logic [7:0] IDX_CORE_CFG     = 8'hF8;
    localparam logic [7:0] IDX_PER_BASE     = 8'hF9;
    localparam int         NUM_PER          = 4;
    localparam int         NUM_EXT          = 8;

    // Central control fields
    localparam int         CC_MFT_EN   = 7;
    localparam int         CC_TL_PEND  = 6;
    localparam int         CC_TL_MASK  = 5;
    localparam int         CC_IEN      = 4;
    localparam int         CC_MODE     = 3;
    localparam logic [7:0] CC_RESET    = 8'h87;
    localparam logic [7:0] PRIO_RESET  = 8'hFF;
    // Hold level register: bit 7 not-maskable, bits 6:0 hold bits
    localparam int         HL_TOP_LEVEL_NOT_MASKABLE     = 7;
    // Core config: bit 0 stack in register file, bit 1 segment push, bits 7:4 vector high
    localparam int         CFG_STACK_RF = 0;
    localparam int         CFG_SEG_PUSH = 1;
    // Peripheral channel: [2:0] level, [3] mask, [4] pending, [14:8] vector
    localparam int         PC_MASK     = 3;
    localparam int         PC_PEND     = 4;
    localparam int         PC_VEC_LO   = 8;

    // Timing in core clock cycles
    localparam logic [2:0] SAMPLE_CYC   = 3'h5;
    localparam logic [4:0] ARB_CYC      = 5'h06;
    localparam logic [4:0] MC_BASE_CYC  = 5'h12;
    localparam logic [4:0] MC_STACK_CYC = 5'h02;
    localparam logic [4:0] MC_SEG_CYC   = 5'h02;
    localparam logic [4:0] MC_WAKE_CYC  = 5'h01;
    localparam logic [2:0] LVL_LOWEST   = 3'h7;
    localparam logic [3:0] SRC_PER0     = 4'h8;
    localparam logic [3:0] SRC_NONE     = 4'hF;

    typedef enum logic [1:0] {S_IDLE, S_ARB, S_WAIT_ABORT, S_MACHINE} iaec_fsm_t;

    // Signals from the CPU sequencer, all one-cycle pulses except the levels noted
    typedef struct packed {
        logic abortable;   // Level: current instruction has made no write yet
        logic instr_end;
        logic wfi;         // Level: core waits for interrupt
        logic ei;
        logic di;
        logic iret;
    } iaec_cpu_t;

    // Service start toward the CPU
    typedef struct packed {
        logic       start;
        logic       top_level;
        logic [6:0] vector;
    } iaec_isr_t;

    typedef struct packed {
        logic [7:0]            ext_s1;
        logic [7:0]            ext_s2;
        logic [7:0]            ext_s3;
        logic                  tl_s1;
        logic                  tl_s2;
        logic                  tl_s3;
        logic [7:0]            cc;
        logic [7:0]            edge_sel;
        logic [7:0]            ext_pend;
        logic [7:0]            ext_mask;
        logic [7:0]            ext_prio;
        logic [7:0]            hold;
        logic [7:0]            cfg;
        logic [NUM_PER-1:0][14:0] per;
        logic [2:0]            div;
        iaec_fsm_t             fsm;
        logic [4:0]            cnt;
        logic [3:0]            win_src;
        logic [2:0]            win_lvl;
        logic                  win_tl;
        logic                  in_tl;
        logic                  bus_done;
        logic [31:0]           rdata;
        iaec_isr_t             isr;
    } iaec_state_t;
endpackage
`default_nettype wire

// file: iaec_arbiter_properties.sv
// Port-level timing checks of the interrupt arbiter, bound to its top module
`default_nettype none
module iaec_arbiter_properties
    import iaec_pkg::*;
(
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               rst,
    // Register bus
    input wire logic [9:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [3:0]         avs_byteenable,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // Interrupt sources
    input wire logic [NUM_EXT-1:0] ext_pin,
    input wire logic               top_level_pin,
    input wire logic [NUM_PER-1:0] per_trigger,
    // Core side
    input wire iaec_cpu_t          cpu,
    input wire logic               irq_request,
    input wire iaec_isr_t          isr,
    input wire logic               multifunction_timer_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic ack;
    logic wr_cc;
    assign ack = irq_request && (cpu.abortable || cpu.instr_end);
    assign wr_cc = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address[9:2] == IDX_CENTRAL_CTRL;
    property p_mft;
        wr_cc |-> ##2 multifunction_timer_enable == $past(avs_writedata[7], 2);
    endproperty
    a_mft: assert property (p_mft) else $error("timer enable wrong");
    property p_hold; irq_request && !ack |=> irq_request; endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_drop; ack |=> !irq_request; endproperty
    a_drop: assert property (p_drop) else $error("request kept after ack");
    property p_mlen; ack |-> ##[18:24] isr.start; endproperty
    a_mlen: assert property (p_mlen) else $error("service start late");
    property p_early; ack |=> !isr.start [*8]; endproperty
    a_early: assert property (p_early) else $error("service start early");
    logic [2:0] div_h;
    always_ff @(posedge core_clk)
        div_h <= (rst || div_h == SAMPLE_CYC - 3'h1) ? 3'h0 : div_h + 3'h1;
    property p_arb; $rose(irq_request) |-> $past(div_h, 7) == SAMPLE_CYC - 3'h1; endproperty
    a_arb: assert property (p_arb) else $error("arbitration too short");
    property p_tlvec; isr.start && isr.top_level |-> isr.vector == 7'h00; endproperty
    a_tlvec: assert property (p_tlvec) else $error("top vector wrong");
    property p_bus;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus wait state wrong");
    c_ext: cover property (isr.start && !isr.top_level);
    c_top: cover property (isr.start && isr.top_level);
    c_slow: cover property (irq_request && !cpu.abortable && cpu.instr_end);
endmodule
bind iaec_arbiter iaec_arbiter_properties chk_u (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_pin,
    .top_level_pin, .per_trigger, .cpu, .irq_request, .isr, .multifunction_timer_enable);
`default_nettype wire

// file: iaec_cpu_model.sv
// Core sequencer model that accepts service requests and returns from them
`default_nettype none
module iaec_cpu_model
    import iaec_pkg::*;
(
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // Behaviour
    input  wire logic      slow,
    input  wire logic      wait_mode,
    // Arbiter side
    input  wire iaec_isr_t isr,
    output var iaec_cpu_t  cpu
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ins_r;
    logic [5:0] svc_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ins_r <= 4'h0;
            svc_r <= 6'h00;
        end else begin
            ins_r <= ins_r + 4'h1;
            svc_r <= isr.start ? 6'h28 : svc_r - {5'h00, svc_r != 6'h00};
        end
    end
    // A slow core has written already, so it stops only at instruction end
    always_comb begin
        cpu = '0;
        cpu.abortable = !slow;
        cpu.instr_end = ins_r == 4'hF;
        cpu.wfi = wait_mode;
        cpu.iret = svc_r == 6'h01;
    end
endmodule
`default_nettype wire

// file: interrupt_arbiter_ext_channels_tb.sv
// Self-checking bench of the interrupt arbiter
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module interrupt_arbiter_ext_channels_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iaec_pkg::*;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rd_val;
    logic [3:0] avs_byteenable = 4'h3;
    logic avs_waitrequest;
    logic irq_request;
    logic mft_en;
    logic [7:0] ext_pin = 8'h00;
    logic top_level_pin = 1'h0;
    logic [3:0] per_trigger = 4'h0;
    logic slow = 1'h0;
    logic wait_mode = 1'h0;
    iaec_cpu_t cpu;
    iaec_isr_t isr;
    int failures = 0, total_checks = 0, cyc = 0, ack_cyc = 0, start_cyc = 0, starts = 0;
    int t0, base;
    logic [7:0] ridx[5] = '{IDX_CENTRAL_CTRL, IDX_EXT_EDGE, IDX_EXT_PEND, IDX_EXT_MASK,
        IDX_EXT_PRIO};
    logic [7:0] rval[5] = '{CC_RESET, 8'h00, 8'h00, 8'h00, PRIO_RESET};
    logic [7:0] row_cfg[4] = '{8'hA3, 8'hA1, 8'hA0, 8'hA0};
    logic [1:0] row_mode[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    int row_add[4] = '{4, 2, 1, 0};
    iaec_arbiter dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_pin, .top_level_pin,
        .per_trigger, .cpu, .irq_request, .isr, .multifunction_timer_enable(mft_en));
    iaec_cpu_model cpu_u (.core_clk, .rst, .slow, .wait_mode, .isr, .cpu);
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (irq_request === 1'h1 && (cpu.abortable || cpu.instr_end)) ack_cyc = cyc;
        if (isr.start === 1'h1) begin
            start_cyc = cyc;
            starts++;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic stop_test();
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'h0};
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'h0) @(posedge core_clk);
        rd_val = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
        bus(1'h0, idx, 32'h0);
        `CHK($sformatf("reg %0h", idx), e, rd_val)
    endtask
    task automatic fire(input logic [8:0] lo, input logic [8:0] hi);
        @(posedge core_clk);
        {top_level_pin, ext_pin} <= lo;
        tick(4);
        @(posedge core_clk);
        {top_level_pin, ext_pin} <= hi;
        #1 t0 = cyc;
    endtask
    task automatic wait_start();
        int n;
        n = 0;
        while (isr.start !== 1'h1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("start", 1'h1, isr.start)
        #1;
    endtask
    task automatic no_start();
        int s;
        s = starts;
        tick(60);
        `CHK("no service", s, starts)
    endtask
    initial begin
        tick(20000);
        failures++;
        stop_test();
    end
    initial begin
        tick(4);
        rst <= 1'h0;
        foreach (ridx[i]) rd_chk(ridx[i], {24'h0, rval[i]});
        `CHK("timer", 1'h1, mft_en)
        bus(1'h1, 8'h00, 32'hFF);
        rd_chk(8'h00, 32'h0);
        bus(1'h1, IDX_CENTRAL_CTRL, 32'h07);
        tick(2);
        `CHK("timer", 1'h0, mft_en)
        bus(1'h1, IDX_CENTRAL_CTRL, 32'h97);
        bus(1'h1, IDX_EXT_EDGE, 32'h81);
        fire(9'h000, 9'h083);
        tick(8);
        rd_chk(IDX_EXT_PEND, 32'h01);
        fire(9'h083, 9'h000);
        tick(8);
        rd_chk(IDX_EXT_PEND, 32'h83);
        bus(1'h1, IDX_EXT_EDGE, 32'h01);
        fire(9'h000, 9'h002);
        bus(1'h1, IDX_EXT_PEND, 32'h00);
        rd_chk(IDX_EXT_PEND, 32'h00);
        bus(1'h1, IDX_EXT_PRIO, 32'hFC);
        bus(1'h1, IDX_CORE_CFG, 32'hA0);
        bus(1'h1, IDX_EXT_MASK, 32'h03);
        fire(9'h002, 9'h001);
        wait_start();
        `CHK("ext latency", 1'h1, (start_cyc - t0) inside {[26:48]})
        `CHK("vector", 7'h50, isr.vector)
        base = start_cyc - ack_cyc;
        rd_chk(IDX_EXT_PEND, 32'h02);
        rd_chk(IDX_CENTRAL_CTRL, 32'h87);
        wait_start();
        `CHK("vector", 7'h51, isr.vector)
        tick(45);
        foreach (row_add[i]) begin
            bus(1'h1, IDX_CORE_CFG, {24'h0, row_cfg[i]});
            {slow, wait_mode} <= row_mode[i];
            fire(9'h000, 9'h001);
            wait_start();
            `CHK("cycle length", base + row_add[i], start_cyc - ack_cyc)
            tick(45);
        end
        {slow, wait_mode} <= 2'h0;
        bus(1'h1, IDX_EXT_PRIO, 32'hFF);
        bus(1'h1, IDX_EXT_PEND, 32'h02);
        no_start();
        rd_chk(IDX_EXT_PEND, 32'h02);
        bus(1'h1, IDX_CENTRAL_CTRL, 32'h91);
        bus(1'h1, IDX_EXT_PRIO, 32'hFC);
        no_start();
        bus(1'h1, IDX_CENTRAL_CTRL, 32'h9B);
        wait_start();
        rd_chk(IDX_CENTRAL_CTRL, 32'h89);
        rd_chk(IDX_HOLD_LEVEL, 32'h08);
        tick(45);
        rd_chk(IDX_CENTRAL_CTRL, 32'h9B);
        bus(1'h1, IDX_PER_BASE, 32'h3302);
        @(posedge core_clk);
        per_trigger <= 4'h1;
        @(posedge core_clk);
        per_trigger <= 4'h0;
        no_start();
        rd_chk(IDX_PER_BASE, 32'h3312);
        bus(1'h1, IDX_PER_BASE, 32'h3302);
        rd_chk(IDX_PER_BASE, 32'h3302);
        bus(1'h1, IDX_PER_BASE, 32'h331A);
        wait_start();
        `CHK("vector", 7'h33, isr.vector)
        tick(45);
        fire(9'h001, 9'h101);
        no_start();
        rd_chk(IDX_CENTRAL_CTRL, 32'hDB);
        bus(1'h1, IDX_HOLD_LEVEL, 32'h80);
        wait_start();
        `CHK("top level", 1'h1, isr.top_level)
        tick(45);
        bus(1'h0, IDX_CENTRAL_CTRL, 32'h0);
        `CHK("central", 3'h1, rd_val[6:4])
        fire(9'h001, 9'h101);
        wait_start();
        `CHK("top latency", 1'h1, (start_cyc - t0) inside {[22:48]})
        stop_test();
    end
endmodule
`default_nettype wire
